// ==== rtl/lail_top.sv ====
`timescale 1ns/10ps
// Operation
// - each of four channels has own mask, edge-select, status registers, 0x40 apart
// - group b mask bit zero enables, one suppresses; all bits reset to one
// - group b bits 7..4: dac overflow, jitter over, jitter under, pattern error
// - group b bits 3..0: excess zeros, code violation, second timer, counter overflow
// - edge-select bits 6..0 per status source; bit 7 reserved; reset zero
// - edge-select zero: only a rising status bit raises an event
// - edge-select one: rising or falling status bit raises an event
// - a status source interrupts only while its mask bit is zero
// - status register is real time and read only; bit 7 reserved
// - activate status sets after code held 40 ms, or 5.1 s with auto loop
// - set loopback status holds while bit error rate stays below one percent
// - rising activate status closes the remote loopback
// - deactivate status qualifies the same way; its rise releases the loopback unless activate rises in the same cycle
// - pattern sync status is one while the pattern receiver is locked
// - transmit clock loss sets after more than 70 cycles without toggle
// - driver fault status is one while a driver short is detected
// - status bit 1 shows alarm indication, bit 0 shows signal loss
// - qualified events latch as pending flags, cleared by reading them
module lail_top #(
    parameter int LB_SHORT_CYCLES = lail_pkg::LB_SHORT_CYCLES,
    parameter int LB_LONG_CYCLES  = lail_pkg::LB_LONG_CYCLES
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // host control port
    input  wire logic [7:0]  host_addr,
    input  wire logic [7:0]  host_wdata,
    input  wire logic        host_write,
    input  wire logic        host_read,
    output logic      [7:0]  host_rdata,
    // per channel detector conditions
    input  wire logic [3:0]  channel_tx_clock,
    input  wire logic [3:0]  auto_remote_loop_enable,
    input  wire logic [3:0]  rx_bit_valid,
    input  wire logic [3:0]  lb_activate_match,
    input  wire logic [3:0]  lb_deactivate_match,
    input  wire logic [3:0]  pattern_sync_lock,
    input  wire logic [3:0]  driver_short,
    input  wire logic [3:0]  alarm_indication,
    input  wire logic [3:0]  signal_loss,
    // per channel group b event pulses
    input  wire logic [31:0] group_b_event,
    // loopback control and interrupt request
    output logic      [3:0]  remote_loop_closed,
    output logic             irq
);
    localparam int NC = lail_pkg::NUM_CHAN;

    typedef struct packed {
        logic [NC-1:0][7:0] mask_a;
        logic [NC-1:0][7:0] mask_b;
        logic [NC-1:0][7:0] edge_sel;
        logic [NC-1:0][7:0] pend_a;
        logic [NC-1:0][7:0] pend_b;
        logic [NC-1:0][6:0] prev_status;
        logic [NC-1:0]      loop_closed;
        logic [7:0]         rdata;
        logic               irq;
    } lail_top_state_type;

    lail_top_state_type state;
    lail_top_state_type next_state;

    logic [NC-1:0]      lb_activate_status;
    logic [NC-1:0]      lb_deactivate_status;
    logic [NC-1:0]      tx_clock_loss_status;
    logic [NC-1:0][6:0] status_now;
    logic [NC-1:0][6:0] rise;
    logic [NC-1:0][6:0] fall;
    logic [NC-1:0][6:0] event_a;
    logic [NC-1:0][7:0] event_b;

    // ************************************************************
    // per channel detectors
    // ************************************************************
    for (genvar ch = 0; ch < NC; ch++) begin : g_chan
        // activate code qualification
        lail_loop_code_qualifier #(
            .SHORT_CYCLES (LB_SHORT_CYCLES),
            .LONG_CYCLES  (LB_LONG_CYCLES),
            .WINDOW_BITS  (lail_pkg::BER_WINDOW_BITS),
            .ERROR_LIMIT  (lail_pkg::BER_ERROR_LIMIT)
        ) u_activate (
            .clock                   (clock),
            .resetn                  (resetn),
            .auto_remote_loop_enable (auto_remote_loop_enable[ch]),
            .bit_valid               (rx_bit_valid[ch]),
            .code_match              (lb_activate_match[ch]),
            .detected                (lb_activate_status[ch])
        );

        // deactivate code qualification
        lail_loop_code_qualifier #(
            .SHORT_CYCLES (LB_SHORT_CYCLES),
            .LONG_CYCLES  (LB_LONG_CYCLES),
            .WINDOW_BITS  (lail_pkg::BER_WINDOW_BITS),
            .ERROR_LIMIT  (lail_pkg::BER_ERROR_LIMIT)
        ) u_deactivate (
            .clock                   (clock),
            .resetn                  (resetn),
            .auto_remote_loop_enable (auto_remote_loop_enable[ch]),
            .bit_valid               (rx_bit_valid[ch]),
            .code_match              (lb_deactivate_match[ch]),
            .detected                (lb_deactivate_status[ch])
        );

        // transmit clock watchdog
        lail_tx_clock_monitor #(
            .LIMIT (lail_pkg::TX_CLOCK_LOSS_CYCLES)
        ) u_tx_clock (
            .clock                (clock),
            .resetn               (resetn),
            .channel_tx_clock     (channel_tx_clock[ch]),
            .tx_clock_loss_status (tx_clock_loss_status[ch])
        );

        // real-time status vector
        assign status_now[ch][lail_pkg::BIT_LB_ACTIVATE]      = lb_activate_status[ch];
        assign status_now[ch][lail_pkg::BIT_LB_DEACTIVATE]    = lb_deactivate_status[ch];
        assign status_now[ch][lail_pkg::BIT_PATTERN_SYNC]     = pattern_sync_lock[ch];
        assign status_now[ch][lail_pkg::BIT_TX_CLOCK_LOSS]    = tx_clock_loss_status[ch];
        assign status_now[ch][lail_pkg::BIT_DRIVER_FAULT]     = driver_short[ch];
        assign status_now[ch][lail_pkg::BIT_ALARM_INDICATION] = alarm_indication[ch];
        assign status_now[ch][lail_pkg::BIT_SIGNAL_LOSS]      = signal_loss[ch];

        // transition detection against last sampled status
        assign rise[ch] = status_now[ch] & ~state.prev_status[ch];
        assign fall[ch] = ~status_now[ch] & state.prev_status[ch];

        // edge selection and masking of status sources
        assign event_a[ch] = ~state.mask_a[ch][6:0]
                           & (rise[ch] | (state.edge_sel[ch][6:0] & fall[ch]));

        // group b sources pass only where the mask bit is zero
        assign event_b[ch] = ~state.mask_b[ch] & group_b_event[ch*8 +: 8];
    end

    // ************************************************************
    // registers, pending flags and loopback control
    // ************************************************************
    always_comb begin
        next_state = state;
        next_state.rdata = state.rdata;
        for (int ch = 0; ch < NC; ch++) begin
            // per channel decode by upper address bits
            next_state.prev_status[ch] = status_now[ch];
            if (host_write && host_addr[7:6] == 2'(ch)) begin
                unique case (host_addr[5:0])
                    lail_pkg::OFS_MASK_A:   next_state.mask_a[ch]   = {1'b0, host_wdata[6:0]};
                    lail_pkg::OFS_MASK_B:   next_state.mask_b[ch]   = host_wdata;
                    lail_pkg::OFS_EDGE_SEL: next_state.edge_sel[ch] = {1'b0, host_wdata[6:0]};
                    default:                next_state.mask_a[ch]   = state.mask_a[ch];
                endcase
            end
            if (host_read && host_addr[7:6] == 2'(ch)) begin
                unique case (host_addr[5:0])
                    lail_pkg::OFS_MASK_A:   next_state.rdata = state.mask_a[ch];
                    lail_pkg::OFS_MASK_B:   next_state.rdata = state.mask_b[ch];
                    lail_pkg::OFS_EDGE_SEL: next_state.rdata = state.edge_sel[ch];
                    lail_pkg::OFS_STATUS:   next_state.rdata = {1'b0, status_now[ch]};
                    lail_pkg::OFS_PEND_A: begin
                        next_state.rdata      = state.pend_a[ch];
                        next_state.pend_a[ch] = 8'h00;
                    end
                    lail_pkg::OFS_PEND_B: begin
                        next_state.rdata      = state.pend_b[ch];
                        next_state.pend_b[ch] = 8'h00;
                    end
                    default:                next_state.rdata = 8'h00;
                endcase
            end
            // new events win over a clearing read in the same cycle
            next_state.pend_a[ch] = next_state.pend_a[ch] | {1'b0, event_a[ch]};
            next_state.pend_b[ch] = next_state.pend_b[ch] | event_b[ch];
            // loopback switch on qualified code edges
            if (rise[ch][lail_pkg::BIT_LB_ACTIVATE]) begin
                next_state.loop_closed[ch] = 1'b1;
            end else if (rise[ch][lail_pkg::BIT_LB_DEACTIVATE]) begin
                next_state.loop_closed[ch] = 1'b0;
            end
        end
        // request follows the pending flags
        next_state.irq = (|next_state.pend_a) | (|next_state.pend_b);
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= '0;
            for (int ch = 0; ch < NC; ch++) begin
                state.mask_a[ch]   <= lail_pkg::MASK_A_RESET;
                state.mask_b[ch]   <= lail_pkg::MASK_B_RESET;
                state.edge_sel[ch] <= lail_pkg::EDGE_SEL_RESET;
            end
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the state register
    assign host_rdata         = state.rdata;
    assign remote_loop_closed = state.loop_closed;
    assign irq                = state.irq;
endmodule : lail_top

// ==== rtl/lail_pkg.sv ====
package lail_pkg;
    // ************************************************************
    // register map, per channel
    // ************************************************************
    localparam logic [7:0] CHAN_STRIDE      = 8'h40;
    localparam logic [5:0] OFS_MASK_A       = 6'h11;
    localparam logic [5:0] OFS_MASK_B       = 6'h12;  // event_mask_group_b
    localparam logic [5:0] OFS_EDGE_SEL     = 6'h13;  // event_edge_select
    localparam logic [5:0] OFS_STATUS       = 6'h14;  // line_realtime_status
    localparam logic [5:0] OFS_PEND_A       = 6'h16;
    localparam logic [5:0] OFS_PEND_B       = 6'h17;
    localparam int         NUM_CHAN         = 4;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] MASK_A_RESET     = 8'h7f;
    localparam logic [7:0] MASK_B_RESET     = 8'hff;
    localparam logic [7:0] EDGE_SEL_RESET   = 8'h00;

    // ************************************************************
    // field positions of status, edge select and group a
    // ************************************************************
    localparam int BIT_LB_ACTIVATE          = 6;
    localparam int BIT_LB_DEACTIVATE        = 5;
    localparam int BIT_PATTERN_SYNC         = 4;
    localparam int BIT_TX_CLOCK_LOSS        = 3;
    localparam int BIT_DRIVER_FAULT         = 2;
    localparam int BIT_ALARM_INDICATION     = 1;
    localparam int BIT_SIGNAL_LOSS          = 0;

    // ************************************************************
    // group b mask positions
    // ************************************************************
    localparam int BIT_DAC_OVERFLOW         = 7;
    localparam int BIT_JITTER_OVER          = 6;
    localparam int BIT_JITTER_UNDER         = 5;
    localparam int BIT_PATTERN_ERROR        = 4;
    localparam int BIT_EXCESS_ZERO          = 3;
    localparam int BIT_CODE_VIOLATION       = 2;
    localparam int BIT_SECOND_TIMER         = 1;
    localparam int BIT_COUNTER_OVERFLOW     = 0;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLOCK_MHZ                = 100;
    localparam int LB_SHORT_TIME_US         = 40000;    // 40 ms
    localparam int LB_LONG_TIME_US          = 5100000;  // 5.1 s
    localparam int LB_SHORT_CYCLES          = LB_SHORT_TIME_US * CLOCK_MHZ;
    localparam int LB_LONG_CYCLES           = LB_LONG_TIME_US * CLOCK_MHZ;
    localparam int TX_CLOCK_LOSS_CYCLES     = 70;
    localparam int BER_WINDOW_BITS          = 1000;
    localparam int BER_ERROR_LIMIT          = 10;       // errors per window that drop detection
endpackage : lail_pkg

// ==== rtl/lail_tx_clock_monitor.sv ====
`timescale 1ns/10ps
module lail_tx_clock_monitor #(
    parameter int LIMIT = lail_pkg::TX_CLOCK_LOSS_CYCLES
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // transmit clock pin, sampled
    input  wire logic channel_tx_clock,
    // loss indication
    output logic      tx_clock_loss_status
);
    typedef struct packed {
        logic       prev_clk;
        logic [7:0] idle;
        logic       lost;
    } lail_tcm_state_type;

    lail_tcm_state_type state;
    lail_tcm_state_type next_state;

    // ************************************************************
    // idle counter, cleared on every toggle
    // ************************************************************
    always_comb begin
        next_state          = state;
        next_state.prev_clk = channel_tx_clock;
        if (channel_tx_clock != state.prev_clk) begin
            next_state.idle = 8'h00;
            next_state.lost = 1'b0;
        end else if (state.idle != 8'(LIMIT)) begin
            next_state.idle = state.idle + 8'h01;
        end else begin
            next_state.lost = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tx_clock_loss_status = state.lost;
endmodule : lail_tx_clock_monitor

// ==== rtl/lail_loop_code_qualifier.sv ====
`timescale 1ns/10ps
module lail_loop_code_qualifier #(
    parameter int SHORT_CYCLES = lail_pkg::LB_SHORT_CYCLES,
    parameter int LONG_CYCLES  = lail_pkg::LB_LONG_CYCLES,
    parameter int WINDOW_BITS  = lail_pkg::BER_WINDOW_BITS,
    parameter int ERROR_LIMIT  = lail_pkg::BER_ERROR_LIMIT
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // long qualification time select
    input  wire logic auto_remote_loop_enable,
    // receive code comparator
    input  wire logic bit_valid,
    input  wire logic code_match,
    // detection status
    output logic      detected
);
    typedef struct packed {
        logic [31:0] qual;
        logic [15:0] win;
        logic [15:0] errs;
        logic        det;
    } lail_lcq_state_type;

    lail_lcq_state_type state;
    lail_lcq_state_type next_state;
    logic [31:0]        target;

    // qualification time follows the auto loop switch
    assign target = auto_remote_loop_enable ? 32'(LONG_CYCLES) : 32'(SHORT_CYCLES);

    // ************************************************************
    // qualify, then hold while error rate stays low
    // ************************************************************
    always_comb begin
        next_state = state;
        if (!state.det) begin
            if (bit_valid && !code_match) begin
                next_state.qual = 32'h0000_0000;               // not continuous, restart
            end else if (state.qual >= target) begin
                next_state.det  = 1'b1;
                next_state.win  = 16'h0000;
                next_state.errs = 16'h0000;
            end else begin
                next_state.qual = state.qual + 32'h0000_0001;
            end
        end else if (bit_valid) begin
            if (state.win == 16'(WINDOW_BITS - 1)) begin
                next_state.win  = 16'h0000;
                next_state.errs = 16'h0000;
                if (state.errs + 16'(!code_match) >= 16'(ERROR_LIMIT)) begin
                    next_state.det  = 1'b0;
                    next_state.qual = 32'h0000_0000;
                end
            end else begin
                next_state.win  = state.win + 16'h0001;
                next_state.errs = state.errs + 16'(!code_match);
            end
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign detected = state.det;
endmodule : lail_loop_code_qualifier

// ==== tb/lail_props.sv ====
`timescale 1ns/10ps
module lail_props #(
    parameter int LB_SHORT_CYCLES = lail_pkg::LB_SHORT_CYCLES
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // host port
    input  wire logic [7:0] host_addr,
    input  wire logic       host_read,
    input  wire logic [7:0] host_rdata,
    // detector conditions
    input  wire logic [3:0] channel_tx_clock,
    input  wire logic [3:0] rx_bit_valid,
    input  wire logic [3:0] lb_activate_match,
    input  wire logic [3:0] pattern_sync_lock,
    input  wire logic [3:0] driver_short,
    input  wire logic [3:0] alarm_indication,
    input  wire logic [3:0] signal_loss,
    // outputs
    input  wire logic [3:0] remote_loop_closed,
    input  wire logic       irq
);
    logic [31:0] clean_cnt;
    logic [7:0]  idle_cnt;
    logic        tx_prev;

    // clean code run and idle transmit clock length on channel 0
    always_ff @(posedge clock) begin
        tx_prev <= channel_tx_clock[0];
        if (!resetn || (rx_bit_valid[0] && !lb_activate_match[0])) begin
            clean_cnt <= 32'h0000_0000;
        end else if (clean_cnt != 32'hffff_ffff) begin
            clean_cnt <= clean_cnt + 32'h0000_0001;
        end
        if (!resetn || (channel_tx_clock[0] != tx_prev)) begin
            idle_cnt <= 8'h00;
        end else if (idle_cnt != 8'hff) begin
            idle_cnt <= idle_cnt + 8'h01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    AST_RESET_OUT: assert property (disable iff (1'b0) !resetn |=>
        (irq == 1'b0 && remote_loop_closed == 4'h0 && host_rdata == 8'h00)) else $error("outputs not cleared by reset");
    AST_RDATA_HOLD: assert property (!host_read |=> $stable(host_rdata)) else $error("read data moved without a read");
    AST_STATUS_LIVE: assert property (host_read && host_addr == 8'h14 |=>
        host_rdata[4] == $past(pattern_sync_lock[0]) &&
        host_rdata[2:0] == $past({driver_short[0], alarm_indication[0], signal_loss[0]})) else $error("status mismatch");
    AST_UNMAPPED: assert property (host_read && host_addr[5:0] == 6'h20 |=> host_rdata == 8'h00) else $error("unmapped read");
    AST_RSVD_BIT7: assert property (host_read && (host_addr[5:0] inside {6'h11, 6'h13, 6'h14, 6'h16})
        |=> !host_rdata[7])
        else $error("reserved bit set");
    AST_LOOP_QUALIFY: assert property ($rose(remote_loop_closed[0]) |-> clean_cnt >= LB_SHORT_CYCLES)
        else $error("loop closed too early");
    AST_TXLOSS_QUIET: assert property (host_read && host_addr == 8'h14 && idle_cnt < 8'h3c |=> !host_rdata[3])
        else $error("clock loss too early");
    AST_TXLOSS_SET: assert property (host_read && host_addr == 8'h14 && idle_cnt > 8'h4b |=> host_rdata[3])
        else $error("clock loss missing");
endmodule : lail_props

bind lail_top lail_props #(.LB_SHORT_CYCLES(LB_SHORT_CYCLES)) u_props (.clock(clock), .resetn(resetn),
    .host_addr(host_addr), .host_read(host_read), .host_rdata(host_rdata), .channel_tx_clock(channel_tx_clock),
    .rx_bit_valid(rx_bit_valid), .lb_activate_match(lb_activate_match), .pattern_sync_lock(pattern_sync_lock),
    .driver_short(driver_short), .alarm_indication(alarm_indication), .signal_loss(signal_loss),
    .remote_loop_closed(remote_loop_closed), .irq(irq));

// ==== tb/lail_top_tb.sv ====
`timescale 1ns/10ps
module lail_top_tb;
    logic        clock, resetn, host_write, host_read, irq;
    logic [7:0]  host_addr, host_wdata, host_rdata;
    logic [3:0]  channel_tx_clock, auto_remote_loop_enable, rx_bit_valid, lb_activate_match, tx_run;
    logic [3:0]  lb_deactivate_match, pattern_sync_lock, driver_short, alarm_indication, signal_loss;
    logic [3:0]  remote_loop_closed;
    logic [31:0] group_b_event;
    int          n_mismatch, checked;

    // ****************
    // clock, transmit clocks and design
    // ****************
    always #5 clock = ~clock;
    always @(negedge clock) channel_tx_clock <= channel_tx_clock ^ tx_run;

    lail_top #(.LB_SHORT_CYCLES(20), .LB_LONG_CYCLES(60)) u_dut (.clock(clock), .resetn(resetn),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_write(host_write), .host_read(host_read),
        .host_rdata(host_rdata), .channel_tx_clock(channel_tx_clock), .auto_remote_loop_enable(auto_remote_loop_enable),
        .rx_bit_valid(rx_bit_valid), .lb_activate_match(lb_activate_match), .lb_deactivate_match(lb_deactivate_match),
        .pattern_sync_lock(pattern_sync_lock), .driver_short(driver_short), .alarm_indication(alarm_indication),
        .signal_loss(signal_loss), .group_b_event(group_b_event), .remote_loop_closed(remote_loop_closed), .irq(irq));

    // ****************
    // shared tasks
    // ****************
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        host_addr = a;
        host_wdata = d;
        host_write = 1'b1;
        @(negedge clock);
        host_write = 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        host_addr = a;
        host_read = 1'b1;
        @(negedge clock);
        host_read = 1'b0;
        check(host_rdata, exp);
    endtask : rd

    task stop_test;
        $display("checked %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // ****************
    // scenarios
    // ****************
    task t_reset;
        rd(8'h12, 8'hff);
        rd(8'hd2, 8'hff);
        rd(8'h13, 8'h00);
        rd(8'h14, 8'h00);
        rd(8'h20, 8'h00);
        check({7'h00, irq}, 8'h00);
        $display("reset values done");
    endtask : t_reset

    task t_regs;
        for (int ch = 0; ch < 4; ch++) wr({ch[1:0], 6'h12}, 8'ha0 | 8'(ch));
        for (int ch = 0; ch < 4; ch++) begin
            rd({ch[1:0], 6'h12}, 8'ha0 | 8'(ch));
            wr({ch[1:0], 6'h12}, 8'hff);
        end
        wr(8'h13, 8'hff);
        rd(8'h13, 8'h7f);
        wr(8'h13, 8'h00);
        wr(8'h14, 8'hff);
        rd(8'h14, 8'h00);
        $display("register access done");
    endtask : t_regs

    task t_status;
        @(negedge clock);
        pattern_sync_lock = 4'h4;
        driver_short = 4'h4;
        alarm_indication = 4'h4;
        signal_loss = 4'h4;
        rd(8'h94, 8'h17);
        rd(8'h96, 8'h00);
        check({7'h00, irq}, 8'h00);
        pattern_sync_lock = 4'h0;
        driver_short = 4'h0;
        alarm_indication = 4'h0;
        signal_loss = 4'h0;
        rd(8'h94, 8'h00);
        $display("live status done");
    endtask : t_status

    task t_group_b;
        for (int b = 0; b < 8; b++) begin
            wr(8'hd2, ~(8'h01 << b));
            group_b_event = 32'hffff_ffff;
            @(negedge clock);
            group_b_event = 32'h0000_0000;
            check({7'h00, irq}, 8'h01);
            rd(8'hd7, 8'h01 << b);
            check({7'h00, irq}, 8'h00);
            rd(8'hd7, 8'h00);
        end
        wr(8'hd2, 8'hff);
        $display("group b events done");
    endtask : t_group_b

    task t_edge;
        wr(8'h11, 8'h7e);
        for (int es = 0; es < 2; es++) begin
            wr(8'h13, 8'(es));
            signal_loss[0] = 1'b1;
            rd(8'h16, 8'h01);
            signal_loss[0] = 1'b0;
            rd(8'h16, 8'(es));
        end
        wr(8'h11, 8'h7f);
        signal_loss[0] = 1'b1;
        rd(8'h16, 8'h00);
        signal_loss[0] = 1'b0;
        wr(8'h13, 8'h00);
        $display("edge select done");
    endtask : t_edge

    task t_txloss;
        wr(8'h11, 8'h77);
        wr(8'h13, 8'h08);
        rd(8'h16, 8'h00);
        tx_run[0] = 1'b0;
        repeat (50) @(negedge clock);
        rd(8'h14, 8'h00);
        repeat (30) @(negedge clock);
        rd(8'h14, 8'h08);
        check({7'h00, irq}, 8'h01);
        rd(8'h16, 8'h08);
        tx_run[0] = 1'b1;
        repeat (5) @(negedge clock);
        rd(8'h14, 8'h00);
        rd(8'h16, 8'h08);
        wr(8'h13, 8'h00);
        $display("transmit clock loss done");
    endtask : t_txloss

    task t_loop;
        wr(8'h11, 8'h1f);
        rd(8'h16, 8'h00);
        lb_activate_match = 4'h5;
        auto_remote_loop_enable = 4'h4;
        repeat (12) @(negedge clock);
        check({4'h0, remote_loop_closed}, 8'h00);
        repeat (12) @(negedge clock);
        check({4'h0, remote_loop_closed}, 8'h01);
        rd(8'h14, 8'h40);
        rd(8'h16, 8'h40);
        for (int e = 0; e < 5; e++) begin
            lb_activate_match[0] = 1'b0;
            @(negedge clock);
            lb_activate_match[0] = 1'b1;
            @(negedge clock);
        end
        rd(8'h14, 8'h40);
        repeat (25) @(negedge clock);
        check({4'h0, remote_loop_closed}, 8'h05);
        lb_deactivate_match = 4'h1;
        repeat (25) @(negedge clock);
        check({4'h0, remote_loop_closed}, 8'h04);
        rd(8'h14, 8'h60);
        rd(8'h16, 8'h20);
        $display("loop code done");
    endtask : t_loop

    // ****************
    // main sequence and watchdog
    // ****************
    initial begin
        {clock, resetn, host_write, host_read, host_addr, host_wdata} = '0;
        {channel_tx_clock, auto_remote_loop_enable, lb_activate_match, lb_deactivate_match} = '0;
        {pattern_sync_lock, driver_short, alarm_indication, signal_loss, group_b_event} = '0;
        tx_run = 4'hf;
        rx_bit_valid = 4'hf;
        n_mismatch = 0;
        checked = 0;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        t_reset;
        t_regs;
        t_status;
        t_group_b;
        t_edge;
        t_txloss;
        t_loop;
        stop_test;
    end

    initial begin
        #200000;
        n_mismatch++;
        stop_test;
    end
endmodule : lail_top_tb
